// ---- rtl/nhg_pkg.sv ----
/*
 Constants, address map and helper functions for the oscillator hop-table
 and gain block. Assumes a byte-wide register port and a single clock.
*/
// Behaviour
// - B gain is one minus backoff over 65536
// - B backoff applies in both combine modes
// - Dither backoff adds on, gain floors at zero
// - Frequency is word times sample rate over 2^32
// - Signed and unsigned words accumulate identically
// - Two 16-word frequency tables, stride four bytes
// - Sixteen 16-bit phase words for A, stride two
// - Word change after sync loses phase determinism
// - Phase word left-justified, added to accumulator
// - Phase offset added after the accumulator
package nhg_pkg;

   localparam int ENTRIES  = 16;
   localparam int IDX_W    = 4;
   localparam int FREQ_W   = 32;
   localparam int PHASE_W  = 16;
   localparam int GAIN_W   = 16;
   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 8;
   localparam int SAMPLE_W = 16;

   localparam logic [ADDR_W-1:0] GAIN_B_LO_ADDR   = 12'h334;
   localparam logic [ADDR_W-1:0] GAIN_B_HI_ADDR   = 12'h335;
   localparam logic [ADDR_W-1:0] EFF_GAIN_LO_ADDR = 12'h336;
   localparam logic [ADDR_W-1:0] EFF_GAIN_HI_ADDR = 12'h337;
   localparam logic [ADDR_W-1:0] EFF_GAIN_TOP_ADDR = 12'h338;
   localparam logic [ADDR_W-1:0] FREQ_A_BASE      = 12'h400;
   localparam logic [ADDR_W-1:0] FREQ_B_BASE      = 12'h440;
   localparam logic [ADDR_W-1:0] PHASE_A_BASE     = 12'h480;
   localparam logic [ADDR_W-1:0] FREQ_SPAN        = 12'h040;
   localparam logic [ADDR_W-1:0] PHASE_SPAN       = 12'h020;

   // Entry index sits above the byte lane bits
   localparam int FREQ_IDX_LSB  = 2;
   localparam int PHASE_IDX_LSB = 1;

   localparam logic [GAIN_W-1:0]  GAIN_B_RESET = 16'h0003;
   localparam logic [GAIN_W:0]    GAIN_UNITY   = 17'h10000;
   localparam logic [FREQ_W-1:0]  FREQ_RESET   = 32'h00000000;
   localparam logic [PHASE_W-1:0] PHASE_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0]  READ_ZERO    = 8'h00;

   function automatic logic in_window(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base,
                                      input logic [ADDR_W-1:0] span);
      in_window = (addr >= base) && (addr < base + span);
   endfunction

   function automatic logic [FREQ_W-1:0] put_byte32(
         input logic [FREQ_W-1:0] old, input logic [1:0] lane,
         input logic [DATA_W-1:0] b);
      logic [FREQ_W-1:0] r;
      r = old;
      r[lane*8 +: 8] = b;
      put_byte32 = r;
   endfunction

   function automatic logic [PHASE_W-1:0] put_byte16(
         input logic [PHASE_W-1:0] old, input logic lane,
         input logic [DATA_W-1:0] b);
      logic [PHASE_W-1:0] r;
      r = old;
      r[lane*8 +: 8] = b;
      put_byte16 = r;
   endfunction

   function automatic logic [SAMPLE_W-1:0] sat_add(
         input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
      logic signed [SAMPLE_W:0] s;
      s = $signed({a[SAMPLE_W-1], a}) + $signed({b[SAMPLE_W-1], b});
      if (s[SAMPLE_W] != s[SAMPLE_W-1])
         sat_add = s[SAMPLE_W] ? 16'h8000 : 16'h7FFF;
      else
         sat_add = s[SAMPLE_W-1:0];
   endfunction

endpackage

// ---- rtl/nhg_osc_if.sv ----
/*
 Carrier between the table logic and one phase accumulator.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface nhg_osc_if;
   logic [nhg_pkg::FREQ_W-1:0]  freq_word;
   logic [nhg_pkg::PHASE_W-1:0] phase_word;
   logic                        sync;
   logic                        enable;
   logic [nhg_pkg::FREQ_W-1:0]  phase;

   modport cfg  (output freq_word, output phase_word, output sync,
                 output enable, input phase);
   modport core (input freq_word, input phase_word, input sync,
                 input enable, output phase);
endinterface
`default_nettype wire

// ---- rtl/nhg_phase_acc.sv ----
/*
 Phase accumulator for one oscillator with a late phase offset.
 Assumes the frequency and phase words are already held stable.
*/
`timescale 1ns/1ns
`default_nettype none
module nhg_phase_acc (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   nhg_osc_if.core   osc
);
   logic [nhg_pkg::FREQ_W-1:0] acc_r;
   logic [nhg_pkg::FREQ_W-1:0] phase_r;

   // Modular wrap makes signed and unsigned words equivalent
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !osc.enable || osc.sync) begin
         acc_r <= nhg_pkg::FREQ_RESET;
      end else begin
         // Running on after a word change keeps no phase reference
         acc_r <= acc_r + osc.freq_word;
      end
   end

   // Offset joins after the accumulator, so it never resets it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         phase_r <= nhg_pkg::FREQ_RESET;
      end else begin
         phase_r <= acc_r + {osc.phase_word, nhg_pkg::PHASE_RESET};
      end
   end

   assign osc.phase = phase_r;
endmodule
`default_nettype wire

// ---- rtl/nhg_gain_b.sv ----
/*
 Gain stage for oscillator B: backoff plus dither backoff, floored at zero.
 Assumes a signed sample arrives every clock.
*/
`timescale 1ns/1ns
`default_nettype none
module nhg_gain_b (
   input  wire logic                          clk_sys,
   input  wire logic                          sys_rst,
   input  wire logic [nhg_pkg::GAIN_W-1:0]    backoff,
   input  wire logic                          dither_enable,
   input  wire logic [nhg_pkg::GAIN_W-1:0]    dither_backoff,
   input  wire logic [nhg_pkg::SAMPLE_W-1:0]  sample_in,
   output var  logic [nhg_pkg::GAIN_W:0]      eff_gain,
   output var  logic [nhg_pkg::SAMPLE_W-1:0]  sample_out
);
   logic [nhg_pkg::GAIN_W:0]   backoff_sum;
   logic signed [33:0]         prod;
   logic [nhg_pkg::SAMPLE_W-1:0] sample_r;

   always_comb begin
      backoff_sum = {1'b0, backoff};
      if (dither_enable)
         backoff_sum = backoff_sum + {1'b0, dither_backoff};
      if (backoff_sum >= nhg_pkg::GAIN_UNITY)
         eff_gain = '0;
      else
         eff_gain = nhg_pkg::GAIN_UNITY - backoff_sum;
      prod = $signed(sample_in) * $signed({1'b0, eff_gain});
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sample_r <= '0;
      end else begin
         sample_r <= prod[31:16];
      end
   end

   assign sample_out = sample_r;
endmodule
`default_nettype wire

// ---- rtl/nhg_top.sv ----
/*
 Hop tables, gain backoff register and oscillator phase paths.
 Assumes a byte-wide register port synchronous to clk_sys; the sine
 lookup that turns phases into samples sits outside.
*/
`timescale 1ns/1ns
`default_nettype none
module nhg_top (
   input  wire logic                            clk_sys,
   input  wire logic                            sys_rst,
   input  wire logic [nhg_pkg::ADDR_W-1:0]      reg_addr,
   input  wire logic [nhg_pkg::DATA_W-1:0]      reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [nhg_pkg::DATA_W-1:0]      reg_rdata,
   input  wire logic                            oscillator_enable,
   input  wire logic                            hop_update_block,
   input  wire logic                            osc_combine_select,
   input  wire logic                            osc_b_dither_enable,
   input  wire logic [nhg_pkg::GAIN_W-1:0]      osc_b_dither_backoff,
   input  wire logic [nhg_pkg::IDX_W-1:0]       hop_index_a,
   input  wire logic [nhg_pkg::IDX_W-1:0]       hop_index_b,
   input  wire logic                            sync_a,
   input  wire logic                            sync_b,
   input  wire logic [nhg_pkg::SAMPLE_W-1:0]    osc_a_sample,
   input  wire logic [nhg_pkg::SAMPLE_W-1:0]    osc_b_sample,
   output logic      [nhg_pkg::FREQ_W-1:0]      phase_a,
   output logic      [nhg_pkg::FREQ_W-1:0]      phase_b,
   output logic      [nhg_pkg::SAMPLE_W-1:0]    osc_a_out,
   output logic      [nhg_pkg::SAMPLE_W-1:0]    osc_b_out
);
   logic [nhg_pkg::GAIN_W-1:0]   osc_b_gain_backoff_r;
   logic [nhg_pkg::FREQ_W-1:0]   hop_frequency_table_a_r [nhg_pkg::ENTRIES];
   logic [nhg_pkg::FREQ_W-1:0]   hop_frequency_table_b_r [nhg_pkg::ENTRIES];
   logic [nhg_pkg::PHASE_W-1:0]  hop_phase_table_a_r [nhg_pkg::ENTRIES];
   logic [nhg_pkg::FREQ_W-1:0]   act_freq_a_r;
   logic [nhg_pkg::FREQ_W-1:0]   act_freq_b_r;
   logic [nhg_pkg::PHASE_W-1:0]  act_phase_a_r;
   logic [nhg_pkg::DATA_W-1:0]   rdata_r;
   logic [nhg_pkg::DATA_W-1:0]   rdata_nxt;
   logic [nhg_pkg::SAMPLE_W-1:0] a_dly_r;
   logic [nhg_pkg::SAMPLE_W-1:0] a_out_r;
   logic [nhg_pkg::SAMPLE_W-1:0] b_out_r;
   logic [nhg_pkg::SAMPLE_W-1:0] b_scaled;
   logic [nhg_pkg::GAIN_W:0]     eff_gain;
   logic [nhg_pkg::ADDR_W-1:0]   off_fa;
   logic [nhg_pkg::ADDR_W-1:0]   off_fb;
   logic [nhg_pkg::ADDR_W-1:0]   off_pa;
   logic [nhg_pkg::IDX_W-1:0]    idx_fa;
   logic [nhg_pkg::IDX_W-1:0]    idx_fb;
   logic [nhg_pkg::IDX_W-1:0]    idx_pa;
   logic                         hit_fa;
   logic                         hit_fb;
   logic                         hit_pa;

   nhg_osc_if osc_a_if ();
   nhg_osc_if osc_b_if ();

   // Address decode shared by read and write paths
   always_comb begin
      off_fa = reg_addr - nhg_pkg::FREQ_A_BASE;
      off_fb = reg_addr - nhg_pkg::FREQ_B_BASE;
      off_pa = reg_addr - nhg_pkg::PHASE_A_BASE;
      idx_fa = off_fa[nhg_pkg::FREQ_IDX_LSB +: nhg_pkg::IDX_W];
      idx_fb = off_fb[nhg_pkg::FREQ_IDX_LSB +: nhg_pkg::IDX_W];
      idx_pa = off_pa[nhg_pkg::PHASE_IDX_LSB +: nhg_pkg::IDX_W];
      hit_fa = nhg_pkg::in_window(reg_addr, nhg_pkg::FREQ_A_BASE,
                                  nhg_pkg::FREQ_SPAN);
      hit_fb = nhg_pkg::in_window(reg_addr, nhg_pkg::FREQ_B_BASE,
                                  nhg_pkg::FREQ_SPAN);
      hit_pa = nhg_pkg::in_window(reg_addr, nhg_pkg::PHASE_A_BASE,
                                  nhg_pkg::PHASE_SPAN);
   end

   // Gain backoff register, low byte at the lower address
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         osc_b_gain_backoff_r <= nhg_pkg::GAIN_B_RESET;
      end else if (reg_wr && reg_addr == nhg_pkg::GAIN_B_LO_ADDR) begin
         osc_b_gain_backoff_r[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == nhg_pkg::GAIN_B_HI_ADDR) begin
         osc_b_gain_backoff_r[15:8] <= reg_wdata;
      end
   end

   // Frequency table A
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < nhg_pkg::ENTRIES; i++) begin
            hop_frequency_table_a_r[i] <= nhg_pkg::FREQ_RESET;
         end
      end else if (reg_wr && hit_fa) begin
         hop_frequency_table_a_r[idx_fa] <= nhg_pkg::put_byte32(
            hop_frequency_table_a_r[idx_fa], off_fa[1:0], reg_wdata);
      end
   end

   // Frequency table B
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < nhg_pkg::ENTRIES; i++) begin
            hop_frequency_table_b_r[i] <= nhg_pkg::FREQ_RESET;
         end
      end else if (reg_wr && hit_fb) begin
         hop_frequency_table_b_r[idx_fb] <= nhg_pkg::put_byte32(
            hop_frequency_table_b_r[idx_fb], off_fb[1:0], reg_wdata);
      end
   end

   // Phase table A
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < nhg_pkg::ENTRIES; i++) begin
            hop_phase_table_a_r[i] <= nhg_pkg::PHASE_RESET;
         end
      end else if (reg_wr && hit_pa) begin
         hop_phase_table_a_r[idx_pa] <= nhg_pkg::put_byte16(
            hop_phase_table_a_r[idx_pa], off_pa[0], reg_wdata);
      end
   end

   // Active words follow the hop index unless updates are blocked;
   // a half-written entry therefore never reaches the core while blocked.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         act_freq_a_r  <= nhg_pkg::FREQ_RESET;
         act_freq_b_r  <= nhg_pkg::FREQ_RESET;
         act_phase_a_r <= nhg_pkg::PHASE_RESET;
      end else if (!hop_update_block) begin
         act_freq_a_r  <= hop_frequency_table_a_r[hop_index_a];
         act_freq_b_r  <= hop_frequency_table_b_r[hop_index_b];
         act_phase_a_r <= hop_phase_table_a_r[hop_index_a];
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = nhg_pkg::READ_ZERO;
      if (reg_addr == nhg_pkg::GAIN_B_LO_ADDR) begin
         rdata_nxt = osc_b_gain_backoff_r[7:0];
      end else if (reg_addr == nhg_pkg::GAIN_B_HI_ADDR) begin
         rdata_nxt = osc_b_gain_backoff_r[15:8];
      end else if (reg_addr == nhg_pkg::EFF_GAIN_LO_ADDR) begin
         rdata_nxt = eff_gain[7:0];
      end else if (reg_addr == nhg_pkg::EFF_GAIN_HI_ADDR) begin
         rdata_nxt = eff_gain[15:8];
      end else if (reg_addr == nhg_pkg::EFF_GAIN_TOP_ADDR) begin
         rdata_nxt = {7'h00, eff_gain[16]};
      end else if (hit_fa) begin
         rdata_nxt = hop_frequency_table_a_r[idx_fa][off_fa[1:0]*8 +: 8];
      end else if (hit_fb) begin
         rdata_nxt = hop_frequency_table_b_r[idx_fb][off_fb[1:0]*8 +: 8];
      end else if (hit_pa) begin
         rdata_nxt = hop_phase_table_a_r[idx_pa][off_pa[0]*8 +: 8];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_r <= nhg_pkg::READ_ZERO;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // Oscillator A carries its phase table; B has no phase offset here
   assign osc_a_if.freq_word  = act_freq_a_r;
   assign osc_a_if.phase_word = act_phase_a_r;
   assign osc_a_if.sync       = sync_a;
   assign osc_a_if.enable     = oscillator_enable;
   assign osc_b_if.freq_word  = act_freq_b_r;
   assign osc_b_if.phase_word = nhg_pkg::PHASE_RESET;
   assign osc_b_if.sync       = sync_b;
   assign osc_b_if.enable     = oscillator_enable;

   nhg_phase_acc u_acc_a (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .osc     (osc_a_if.core)
   );

   nhg_phase_acc u_acc_b (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .osc     (osc_b_if.core)
   );

   nhg_gain_b u_gain_b (
      .clk_sys        (clk_sys),
      .sys_rst        (sys_rst),
      .backoff        (osc_b_gain_backoff_r),
      .dither_enable  (osc_b_dither_enable),
      .dither_backoff (osc_b_dither_backoff),
      .sample_in      (osc_b_sample),
      .eff_gain       (eff_gain),
      .sample_out     (b_scaled)
   );

   // A is delayed to line up with the scaled B sample
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         a_dly_r <= '0;
      end else begin
         a_dly_r <= osc_a_sample;
      end
   end

   // Scaled B is used in both modes; summing only changes the outputs
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         a_out_r <= '0;
         b_out_r <= '0;
      end else if (osc_combine_select) begin
         a_out_r <= nhg_pkg::sat_add(a_dly_r, b_scaled);
         b_out_r <= nhg_pkg::sat_add(a_dly_r, b_scaled);
      end else begin
         a_out_r <= a_dly_r;
         b_out_r <= b_scaled;
      end
   end

   assign reg_rdata = rdata_r;
   assign phase_a   = osc_a_if.phase;
   assign phase_b   = osc_b_if.phase;
   assign osc_a_out = a_out_r;
   assign osc_b_out = b_out_r;
endmodule
`default_nettype wire

// ---- verification/nhg_monitor.sv ----
/*
 Port checker for nhg_top: readback, phase paths and output paths.
 Assumes the single clk_sys domain; bound at the foot of this file.
*/
`timescale 1ns/1ns
`default_nettype none
module nhg_monitor (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        oscillator_enable,
   input wire logic        hop_update_block,
   input wire logic        osc_combine_select,
   input wire logic        sync_a,
   input wire logic        sync_b,
   input wire logic [15:0] osc_a_sample,
   input wire logic [31:0] phase_a,
   input wire logic [31:0] phase_b,
   input wire logic [15:0] osc_a_out,
   input wire logic [15:0] osc_b_out
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   a_rdata_idle_hold: assert property (
      !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
   a_unmapped_read_zero: assert property (
      reg_rd && reg_addr >= 12'h4A0 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_phase_low_clear: assert property (
      !oscillator_enable |-> ##2 phase_a[15:0] == 16'h0000)
      else $error("phase low half not zero");
   a_disabled_b_zero: assert property (
      !oscillator_enable |-> ##2 phase_b == 32'h00000000)
      else $error("phase b not cleared");
   a_sync_b_zero: assert property (
      sync_b |-> ##2 phase_b == 32'h00000000)
      else $error("phase b not held by sync");
   a_frozen_b_step: assert property (
      (oscillator_enable && !sync_b && hop_update_block)[*4] |->
      phase_b - $past(phase_b) == $past(phase_b) - $past(phase_b, 2))
      else $error("phase b step moved while frozen");
   a_frozen_a_step: assert property (
      (oscillator_enable && !sync_a && hop_update_block)[*4] |->
      phase_a - $past(phase_a) == $past(phase_a) - $past(phase_a, 2))
      else $error("phase a step moved while frozen");
   a_path_a_direct: assert property (
      (!osc_combine_select)[*3] |-> osc_a_out == $past(osc_a_sample, 2))
      else $error("osc a path wrong");
   a_combine_equal: assert property (
      osc_combine_select[*3] |-> osc_a_out == osc_b_out)
      else $error("combined outputs differ");

   c_unmapped: cover property (reg_rd && reg_addr >= 12'h4A0);
   c_combine: cover property (osc_combine_select[*3]);
   c_frozen: cover property ((oscillator_enable && hop_update_block)[*4]);
endmodule

bind nhg_top nhg_monitor mon_u (.clk_sys, .sys_rst, .reg_addr, .reg_rd,
   .reg_rdata, .oscillator_enable, .hop_update_block, .osc_combine_select,
   .sync_a, .sync_b, .osc_a_sample, .phase_a, .phase_b, .osc_a_out,
   .osc_b_out);
`default_nettype wire

// ---- verification/tb_nhg_top.sv ----
/*
 Self-checking bench for nhg_top: registers, gain and hop phase paths.
 Assumes the checker is bound separately; inputs move on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   err_count++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
   end end
module tb_nhg_top;
   logic        clk_sys = 1'b0, sys_rst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, oscillator_enable = 1'b0;
   logic        hop_update_block = 1'b0, osc_combine_select = 1'b0;
   logic        osc_b_dither_enable = 1'b0, sync_a = 1'b0, sync_b = 1'b0;
   logic [15:0] osc_b_dither_backoff = 16'h0000;
   logic [15:0] osc_a_sample = 16'h0000, osc_b_sample = 16'h0000;
   logic [3:0]  hop_index_a = 4'h0, hop_index_b = 4'h0;
   logic [31:0] phase_a, phase_b;
   logic [15:0] osc_a_out, osc_b_out;
   int          err_count = 0, samples_checked = 0;

   nhg_top dut_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .oscillator_enable, .hop_update_block,
      .osc_combine_select, .osc_b_dither_enable, .osc_b_dither_backoff,
      .hop_index_a, .hop_index_b, .sync_a, .sync_b, .osc_a_sample,
      .osc_b_sample, .phase_a, .phase_b, .osc_a_out, .osc_b_out);

   always #25 clk_sys = ~clk_sys;

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      `CHK(reg_rdata, e)
   endtask
   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      for (int k = 0; k < 4; k++)
         wr(a + 12'(k), d[8*k +: 8]);
   endtask
   task automatic rd32(input logic [11:0] a, input logic [31:0] e);
      for (int k = 0; k < 4; k++)
         rd(a + 12'(k), e[8*k +: 8]);
   endtask
   task automatic steps(input logic [31:0] fa, input logic [31:0] fb);
      logic [31:0] pa, pb;
      @(negedge clk_sys);
      pa = phase_a;
      pb = phase_b;
      @(negedge clk_sys);
      `CHK(phase_a - pa, fa)
      `CHK(phase_b - pb, fb)
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic t_reset_vals();
      rd(nhg_pkg::GAIN_B_LO_ADDR, 8'h03);
      rd(nhg_pkg::GAIN_B_HI_ADDR, 8'h00);
      rd(nhg_pkg::EFF_GAIN_LO_ADDR, 8'hFD);
      rd(nhg_pkg::EFF_GAIN_HI_ADDR, 8'hFF);
      rd32(nhg_pkg::FREQ_A_BASE + 12'h03C, 32'h00000000);
      rd32(nhg_pkg::FREQ_B_BASE, 32'h00000000);
      rd(nhg_pkg::PHASE_A_BASE + 12'h01F, 8'h00);
      $display("test reset values done");
   endtask

   task automatic t_tables();
      wr32(nhg_pkg::FREQ_A_BASE + 12'h03C, 32'hA1B2C3D4);
      wr32(nhg_pkg::FREQ_B_BASE, 32'h0102F0E0);
      wr(nhg_pkg::PHASE_A_BASE + 12'h01E, 8'h5A);
      wr(nhg_pkg::PHASE_A_BASE + 12'h01F, 8'hC3);
      wr(12'h4A0, 8'h77);
      rd32(nhg_pkg::FREQ_A_BASE + 12'h03C, 32'hA1B2C3D4);
      rd32(nhg_pkg::FREQ_A_BASE + 12'h038, 32'h00000000);
      rd32(nhg_pkg::FREQ_B_BASE, 32'h0102F0E0);
      rd(nhg_pkg::PHASE_A_BASE + 12'h01E, 8'h5A);
      rd(nhg_pkg::PHASE_A_BASE + 12'h01F, 8'hC3);
      rd(12'h4A0, 8'h00);
      $display("test tables done");
   endtask

   task automatic t_gain();
      osc_b_dither_backoff = 16'h0200;
      wr(nhg_pkg::GAIN_B_LO_ADDR, 8'h00);
      wr(nhg_pkg::GAIN_B_HI_ADDR, 8'h10);
      osc_b_sample = 16'h4000;
      settle(4);
      `CHK(osc_b_out, 16'h3C00)
      osc_b_sample = 16'hC000;
      settle(4);
      `CHK(osc_b_out, 16'hC400)
      osc_b_dither_enable = 1'b1;
      osc_b_sample = 16'h4000;
      settle(4);
      `CHK(osc_b_out, 16'h3B80)
      rd(nhg_pkg::EFF_GAIN_HI_ADDR, 8'hEE);
      osc_combine_select = 1'b1;
      osc_a_sample = 16'h7000;
      settle(4);
      `CHK(osc_a_out, 16'h7FFF)
      `CHK(osc_b_out, 16'h7FFF)
      osc_combine_select = 1'b0;
      osc_b_dither_backoff = 16'h0100;
      wr(nhg_pkg::GAIN_B_LO_ADDR, 8'hFF);
      wr(nhg_pkg::GAIN_B_HI_ADDR, 8'hFF);
      settle(4);
      `CHK(osc_b_out, 16'h0000)
      `CHK(osc_a_out, 16'h7000)
      rd(nhg_pkg::EFF_GAIN_LO_ADDR, 8'h00);
      rd(nhg_pkg::EFF_GAIN_HI_ADDR, 8'h00);
      rd(nhg_pkg::EFF_GAIN_TOP_ADDR, 8'h00);
      $display("test gain done");
   endtask

   task automatic t_hop();
      logic [31:0] pa;
      wr32(nhg_pkg::FREQ_A_BASE + 12'h004, 32'h10000000);
      wr32(nhg_pkg::FREQ_B_BASE + 12'h008, 32'hF0000000);
      wr32(nhg_pkg::FREQ_B_BASE, 32'h00000100);
      wr(nhg_pkg::PHASE_A_BASE + 12'h002, 8'h34);
      wr(nhg_pkg::PHASE_A_BASE + 12'h003, 8'h12);
      hop_index_a = 4'h1;
      hop_index_b = 4'h2;
      sync_a = 1'b1;
      sync_b = 1'b1;
      oscillator_enable = 1'b1;
      settle(4);
      `CHK(phase_a, 32'h12340000)
      sync_a = 1'b0;
      sync_b = 1'b0;
      settle(4);
      steps(32'h10000000, 32'hF0000000);
      hop_update_block = 1'b1;
      hop_index_b = 4'h0;
      wr(nhg_pkg::PHASE_A_BASE + 12'h003, 8'h13);
      settle(3);
      steps(32'h10000000, 32'hF0000000);
      pa = phase_a;
      hop_update_block = 1'b0;
      settle(6);
      `CHK(phase_a, pa + 32'h61000000)
      steps(32'h10000000, 32'h00000100);
      oscillator_enable = 1'b0;
      settle(4);
      `CHK(phase_a, 32'h13340000)
      $display("test hop done");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      end_of_test();
   end

   initial begin
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset_vals();
      t_tables();
      t_gain();
      t_hop();
      end_of_test();
   end
endmodule
`default_nettype wire
